// ===== logic/serial_port_pkg.sv
// Summary of operation
// - Port answers only while chip enable low.
// - Select high means mode or command word on write, status on read.
// - Second control word is command, sets control.
// - Select low means character data transfer.
// - Strobes ignored unless chip enable low.
// - Drive data bus only during host read.
// - Receive-ready rises when character waits.
// - Receive-ready clears when host reads data.
// - Transmit-ready high while new character accepted; here high only when transmit enabled and buffer empty.
// - Host write clears transmit-ready, character sent.
// - No transmission start unless clear-to-send low.
// - Terminal-ready low means port ready to receive.
// - Only addressed unit asserts terminal-ready; chain repeats.
// - Request-to-send low means port ready to transmit.
// - Frame: start, eight data, optional parity, stop.
// - Serial data inverted between port and bus.
// - High reset input returns port to initial state.
// - Shift on transmit falling, sample receive rising.
// - Bit clocks divided by sixteen per bit.
package serial_port_pkg;
    localparam logic [15:0] SERIAL_DATA_PORT = 16'h1020;
    localparam logic [15:0] CONTROL_WORD_PORT = 16'h1021;
    localparam int DATA_W = 8;
    localparam int BUF_DEPTH = 2;
    localparam int PIN_W = 19;
    // Mode word fields
    localparam int MODE_PAR_EN = 0;
    localparam int MODE_PAR_EVEN = 1;
    localparam logic [7:0] MODE_RESET = 8'h00;
    // Command word fields
    localparam int CMD_TX_EN = 0;
    localparam int CMD_DTR = 1;
    localparam int CMD_RX_EN = 2;
    localparam int CMD_ERR_CLR = 4;
    localparam int CMD_RTS = 5;
    localparam int CMD_SOFT_RST = 6;
    localparam logic [7:0] CMD_RESET = 8'h00;
    // Status word fields
    localparam int STAT_TX_RDY = 0;
    localparam int STAT_RX_RDY = 1;
    localparam int STAT_TX_EMPTY = 2;
    localparam int STAT_PAR_ERR = 3;
    localparam int STAT_OVR_ERR = 4;
    localparam int STAT_FRM_ERR = 5;
    localparam int STAT_DSR = 7;
    // Bit timing in bit-clock ticks
    localparam logic [3:0] TICK_LAST = 4'hF;
    localparam logic [3:0] TICK_HALF = 4'h7;
    localparam logic [2:0] DATA_LAST = 3'h7;

    typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_PAR, S_STOP} frame_e;
endpackage

// ===== logic/tx_hold_buffer.sv
`timescale 1ns/1ps
module tx_hold_buffer (
    // Clock and clear
    input wire logic clk,
    input wire logic clr,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [serial_port_pkg::DATA_W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [serial_port_pkg::DATA_W-1:0] out_data
);
    logic [serial_port_pkg::DATA_W-1:0] mem_q [serial_port_pkg::BUF_DEPTH];
    logic wr_idx_q;
    logic rd_idx_q;
    logic [1:0] count_q;
    logic push;
    logic pop;

    assign in_ready = (count_q != 2'h2);
    assign out_valid = (count_q != 2'h0);
    assign out_data = mem_q[rd_idx_q];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_idx_q] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (clr) begin
            wr_idx_q <= 1'b0;
            rd_idx_q <= 1'b0;
            count_q <= 2'h0;
        end else begin
            if (push) begin
                wr_idx_q <= ~wr_idx_q;
            end
            if (pop) begin
                rd_idx_q <= ~rd_idx_q;
            end
            if (push && !pop) begin
                count_q <= count_q + 2'h1;
            end else if (pop && !push) begin
                count_q <= count_q - 2'h1;
            end
        end
    end
endmodule

// ===== logic/serial_port_device.sv
`timescale 1ns/1ps
module serial_port_device (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic port_reset,
    // Host bus
    input wire logic chip_enable_n,
    input wire logic ctrl_data_sel,
    input wire logic read_n,
    input wire logic write_n,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    // Host requests
    output logic rx_ready,
    output logic tx_ready,
    // Bit clocks, 16x baud
    input wire logic receive_bit_clock_n,
    input wire logic transmit_bit_clock_n,
    // Handshake link
    input wire logic clear_to_send_n,
    input wire logic data_set_ready_n,
    input wire logic unit_addressed,
    input wire logic chain_terminal_ready_n,
    input wire logic chain_request_to_send_n,
    output logic terminal_ready_n,
    output logic request_to_send_n,
    // Serial bus, inverted sense
    input wire logic serial_rx_line,
    output logic serial_tx_line
);
    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [serial_port_pkg::PIN_W-1:0] pin_raw;
    logic [serial_port_pkg::PIN_W-1:0] s1_q;
    logic [serial_port_pkg::PIN_W-1:0] s2_q;
    logic [serial_port_pkg::PIN_W-1:0] s3_q;
    logic [serial_port_pkg::PIN_W-1:0] pin_q;
    logic cs_n_s, cd_s, rd_n_s, wr_n_s, cts_n_s, dsr_n_s, rxl_s, rxc_s, txc_s;
    logic prst_s, addr_s;
    logic [7:0] din_s;

    // A bit changes only once the second and third stages agree
    function automatic logic [serial_port_pkg::PIN_W-1:0] settle(
        input logic [serial_port_pkg::PIN_W-1:0] a,
        input logic [serial_port_pkg::PIN_W-1:0] b,
        input logic [serial_port_pkg::PIN_W-1:0] cur);
        settle = (a & b) | (cur & (a | b));
    endfunction

    assign pin_raw = {chip_enable_n, ctrl_data_sel, read_n, write_n, data_in,
                      clear_to_send_n, data_set_ready_n, serial_rx_line,
                      receive_bit_clock_n, transmit_bit_clock_n, port_reset,
                      unit_addressed};
    assign {cs_n_s, cd_s, rd_n_s, wr_n_s, din_s, cts_n_s, dsr_n_s, rxl_s,
            rxc_s, txc_s, prst_s, addr_s} = pin_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_q <= {serial_port_pkg::PIN_W{1'b1}};
            s2_q <= {serial_port_pkg::PIN_W{1'b1}};
            s3_q <= {serial_port_pkg::PIN_W{1'b1}};
            pin_q <= {serial_port_pkg::PIN_W{1'b1}};
        end else begin
            s1_q <= pin_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            pin_q <= settle(s2_q, s3_q, pin_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Strobe decode and soft reset

    logic wr_prev_q, rd_prev_q, rxc_prev_q, txc_prev_q;
    logic wr_start, rd_end, sel, ctl_wr, dat_wr, dat_rd_end;
    logic rd_data_q, soft_rst, int_rst, rx_tick, tx_tick;

    assign sel = !cs_n_s;
    assign wr_start = sel && !wr_n_s && wr_prev_q;
    assign rd_end = rd_n_s && !rd_prev_q && rd_data_q;
    assign ctl_wr = wr_start && cd_s;
    assign dat_wr = wr_start && !cd_s;
    assign dat_rd_end = rd_end;
    assign rx_tick = rxc_s && !rxc_prev_q;
    assign tx_tick = !txc_s && txc_prev_q;
    assign int_rst = !rst_n || prst_s || soft_rst;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_prev_q <= 1'b1;
            rd_prev_q <= 1'b1;
            rxc_prev_q <= 1'b1;
            txc_prev_q <= 1'b1;
            rd_data_q <= 1'b0;
        end else begin
            wr_prev_q <= wr_n_s;
            rd_prev_q <= rd_n_s;
            rxc_prev_q <= rxc_s;
            txc_prev_q <= txc_s;
            // Remember a data read in progress so its end frees the holding register
            if (sel && !rd_n_s) begin
                rd_data_q <= !cd_s;
            end else if (rd_n_s) begin
                rd_data_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode and command words

    logic expect_mode_q;
    logic [7:0] mode_q, cmd_q;
    logic err_clr;

    assign soft_rst = ctl_wr && !expect_mode_q && din_s[serial_port_pkg::CMD_SOFT_RST];
    assign err_clr = ctl_wr && !expect_mode_q && din_s[serial_port_pkg::CMD_ERR_CLR];

    always_ff @(posedge clk) begin
        if (int_rst) begin
            expect_mode_q <= 1'b1;
            mode_q <= serial_port_pkg::MODE_RESET;
            cmd_q <= serial_port_pkg::CMD_RESET;
        end else if (ctl_wr) begin
            if (expect_mode_q) begin
                mode_q <= din_s;
                expect_mode_q <= 1'b0;
            end else begin
                cmd_q <= din_s;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receiver

    serial_port_pkg::frame_e rx_st_q;
    logic [3:0] rx_cnt_q;
    logic [2:0] rx_bit_q;
    logic [7:0] rx_sh_q, rx_hold_q;
    logic rx_done, rx_line, rx_par_q, par_err_q, ovr_err_q, frm_err_q;
    logic rx_ready_q, rx_perr_now;

    assign rx_line = !rxl_s;
    assign rx_done = rx_tick && rx_st_q == serial_port_pkg::S_STOP
                     && rx_cnt_q == serial_port_pkg::TICK_LAST;

    always_ff @(posedge clk) begin
        if (int_rst || !cmd_q[serial_port_pkg::CMD_RX_EN]) begin
            rx_st_q <= serial_port_pkg::S_IDLE;
            rx_cnt_q <= 4'h0;
            rx_bit_q <= 3'h0;
            rx_sh_q <= 8'h00;
            rx_par_q <= 1'b0;
        end else if (rx_tick) begin
            rx_cnt_q <= rx_cnt_q + 4'h1;
            unique case (rx_st_q)
                serial_port_pkg::S_IDLE: begin
                    rx_cnt_q <= 4'h0;
                    if (!rx_line) begin
                        rx_st_q <= serial_port_pkg::S_START;
                    end
                end
                serial_port_pkg::S_START: begin
                    // Recheck mid-bit so a glitch does not start a frame
                    if (rx_cnt_q == serial_port_pkg::TICK_HALF) begin
                        rx_cnt_q <= 4'h0;
                        rx_bit_q <= 3'h0;
                        rx_st_q <= rx_line ? serial_port_pkg::S_IDLE : serial_port_pkg::S_DATA;
                    end
                end
                serial_port_pkg::S_DATA: begin
                    if (rx_cnt_q == serial_port_pkg::TICK_LAST) begin
                        rx_sh_q <= {rx_line, rx_sh_q[7:1]};
                        rx_bit_q <= rx_bit_q + 3'h1;
                        if (rx_bit_q == serial_port_pkg::DATA_LAST) begin
                            rx_st_q <= mode_q[serial_port_pkg::MODE_PAR_EN]
                                       ? serial_port_pkg::S_PAR : serial_port_pkg::S_STOP;
                        end
                    end
                end
                serial_port_pkg::S_PAR: begin
                    if (rx_cnt_q == serial_port_pkg::TICK_LAST) begin
                        rx_par_q <= rx_line;
                        rx_st_q <= serial_port_pkg::S_STOP;
                    end
                end
                serial_port_pkg::S_STOP: begin
                    if (rx_cnt_q == serial_port_pkg::TICK_LAST) begin
                        rx_st_q <= serial_port_pkg::S_IDLE;
                    end
                end
            endcase
        end
    end

    // Parity: data plus parity bit has an even count of ones with MODE_PAR_EVEN set, odd when clear
    assign rx_perr_now = mode_q[serial_port_pkg::MODE_PAR_EN]
        && ((^rx_sh_q ^ rx_par_q) != !mode_q[serial_port_pkg::MODE_PAR_EVEN]);

    always_ff @(posedge clk) begin
        if (int_rst) begin
            rx_ready_q <= 1'b0;
            rx_hold_q <= 8'h00;
            par_err_q <= 1'b0;
            ovr_err_q <= 1'b0;
            frm_err_q <= 1'b0;
        end else begin
            // New character beats a read ending in the same cycle
            if (rx_done && (!rx_ready_q || dat_rd_end)) begin
                rx_ready_q <= 1'b1;
                rx_hold_q <= rx_sh_q;
            end else if (dat_rd_end) begin
                rx_ready_q <= 1'b0;
            end
            if (rx_done && rx_ready_q && !dat_rd_end) begin
                ovr_err_q <= 1'b1;
            end else if (err_clr) begin
                ovr_err_q <= 1'b0;
            end
            if (rx_done && !rx_line) begin
                frm_err_q <= 1'b1;
            end else if (err_clr) begin
                frm_err_q <= 1'b0;
            end
            if (rx_done && rx_perr_now) begin
                par_err_q <= 1'b1;
            end else if (err_clr) begin
                par_err_q <= 1'b0;
            end
        end
    end

    assign rx_ready = rx_ready_q;

    ////////////////////////////////////////////////////////////////////////////
    // Transmit buffer

    logic buf_in_ready, buf_out_valid, buf_take;
    logic [7:0] buf_out_data;
    logic tx_ready_q, tx_en;

    assign tx_en = cmd_q[serial_port_pkg::CMD_TX_EN];

    tx_hold_buffer u_buf (
        .clk(clk),
        .clr(int_rst),
        .in_valid(dat_wr),
        .in_ready(buf_in_ready),
        .in_data(din_s),
        .out_valid(buf_out_valid),
        .out_ready(buf_take),
        .out_data(buf_out_data)
    );

    always_ff @(posedge clk) begin
        if (int_rst) begin
            tx_ready_q <= 1'b0;
        end else if (dat_wr) begin
            tx_ready_q <= 1'b0;
        end else begin
            tx_ready_q <= tx_en && !buf_out_valid;
        end
    end

    assign tx_ready = tx_ready_q;

    ////////////////////////////////////////////////////////////////////////////
    // Transmitter

    serial_port_pkg::frame_e tx_st_q;
    logic [3:0] tx_cnt_q;
    logic [2:0] tx_bit_q;
    logic [7:0] tx_sh_q;
    logic tx_level_q, tx_par_q, tx_bit_end;

    assign tx_bit_end = tx_tick && tx_cnt_q == serial_port_pkg::TICK_LAST;
    assign buf_take = tx_st_q == serial_port_pkg::S_IDLE && tx_en && !cts_n_s;

    always_ff @(posedge clk) begin
        if (int_rst) begin
            tx_st_q <= serial_port_pkg::S_IDLE;
            tx_cnt_q <= 4'h0;
            tx_bit_q <= 3'h0;
            tx_sh_q <= 8'h00;
            tx_par_q <= 1'b0;
            tx_level_q <= 1'b1;
        end else begin
            if (tx_tick && tx_st_q != serial_port_pkg::S_IDLE) begin
                tx_cnt_q <= tx_cnt_q + 4'h1;
            end
            unique case (tx_st_q)
                serial_port_pkg::S_IDLE: begin
                    tx_cnt_q <= 4'h0;
                    tx_level_q <= 1'b1;
                    if (buf_take && buf_out_valid) begin
                        tx_sh_q <= buf_out_data;
                        tx_par_q <= ^buf_out_data ^ !mode_q[serial_port_pkg::MODE_PAR_EVEN];
                        tx_st_q <= serial_port_pkg::S_START;
                    end
                end
                serial_port_pkg::S_START: begin
                    // Line changes only on a falling bit clock edge
                    // Count restarts at the falling edge so the start bit is a full bit
                    if (tx_tick && tx_level_q) begin
                        tx_level_q <= 1'b0;
                        tx_cnt_q <= 4'h0;
                    end
                    if (tx_bit_end) begin
                        tx_bit_q <= 3'h0;
                        tx_level_q <= tx_sh_q[0];
                        tx_st_q <= serial_port_pkg::S_DATA;
                    end
                end
                serial_port_pkg::S_DATA: begin
                    if (tx_bit_end) begin
                        tx_sh_q <= {1'b0, tx_sh_q[7:1]};
                        tx_bit_q <= tx_bit_q + 3'h1;
                        tx_level_q <= tx_sh_q[1];
                        if (tx_bit_q == serial_port_pkg::DATA_LAST) begin
                            tx_level_q <= mode_q[serial_port_pkg::MODE_PAR_EN]
                                          ? tx_par_q : 1'b1;
                            tx_st_q <= mode_q[serial_port_pkg::MODE_PAR_EN]
                                       ? serial_port_pkg::S_PAR : serial_port_pkg::S_STOP;
                        end
                    end
                end
                serial_port_pkg::S_PAR: begin
                    if (tx_bit_end) begin
                        tx_level_q <= 1'b1;
                        tx_st_q <= serial_port_pkg::S_STOP;
                    end
                end
                serial_port_pkg::S_STOP: begin
                    if (tx_bit_end) begin
                        tx_st_q <= serial_port_pkg::S_IDLE;
                    end
                end
            endcase
        end
    end

    assign serial_tx_line = !tx_level_q;

    ////////////////////////////////////////////////////////////////////////////
    // Handshake outputs and host read data

    logic dtr_local_n_q, rts_local_n_q, oe_q;
    logic [7:0] dout_q, status;

    always_ff @(posedge clk) begin
        if (int_rst) begin
            dtr_local_n_q <= 1'b1;
            rts_local_n_q <= 1'b1;
        end else begin
            dtr_local_n_q <= !(cmd_q[serial_port_pkg::CMD_DTR] && addr_s);
            rts_local_n_q <= !cmd_q[serial_port_pkg::CMD_RTS];
        end
    end

    // Repeater path: a low from further down the chain is passed toward the controller
    assign terminal_ready_n = dtr_local_n_q && chain_terminal_ready_n;
    assign request_to_send_n = rts_local_n_q && chain_request_to_send_n;

    always_comb begin
        status = 8'h00;
        status[serial_port_pkg::STAT_TX_RDY] = tx_ready_q;
        status[serial_port_pkg::STAT_RX_RDY] = rx_ready_q;
        status[serial_port_pkg::STAT_TX_EMPTY] = !buf_out_valid
                                                && tx_st_q == serial_port_pkg::S_IDLE;
        status[serial_port_pkg::STAT_PAR_ERR] = par_err_q;
        status[serial_port_pkg::STAT_OVR_ERR] = ovr_err_q;
        status[serial_port_pkg::STAT_FRM_ERR] = frm_err_q;
        status[serial_port_pkg::STAT_DSR] = !dsr_n_s;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            oe_q <= 1'b0;
            dout_q <= 8'h00;
        end else begin
            oe_q <= sel && !rd_n_s;
            dout_q <= cd_s ? status : rx_hold_q;
        end
    end

    assign data_oe = oe_q;
    assign data_out = dout_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    AST_STROBE_NEEDS_CS: assert property (@(posedge clk) disable iff (!rst_n)
        (cs_n_s && !wr_n_s && wr_prev_q && !prst_s) |=> $stable(cmd_q) && $stable(mode_q))
        else $error("Write strobe acted without chip enable");
    AST_OE_ONLY_ON_READ: assert property (@(posedge clk) disable iff (!rst_n)
        data_oe |-> $past(!cs_n_s && !rd_n_s))
        else $error("Data bus driven outside a read");
    AST_RXRDY_CLEARS: assert property (@(posedge clk) disable iff (!rst_n)
        (dat_rd_end && !rx_done) |=> !rx_ready)
        else $error("Receive-ready not cleared by data read");
    AST_RXRDY_HOLDS: assert property (@(posedge clk) disable iff (!rst_n)
        (rx_ready && !dat_rd_end && !int_rst) |=> rx_ready && $stable(rx_hold_q))
        else $error("Received character lost before read");
    AST_TXRDY_CLEARS: assert property (@(posedge clk) disable iff (!rst_n)
        dat_wr |=> !tx_ready ##1 buf_out_valid || tx_st_q != serial_port_pkg::S_IDLE)
        else $error("Transmit-ready not cleared or character dropped");
    AST_CTS_GATES_START: assert property (@(posedge clk) disable iff (!rst_n)
        (tx_st_q == serial_port_pkg::S_IDLE ##1 tx_st_q == serial_port_pkg::S_START)
        |-> $past(!cts_n_s, 1))
        else $error("Transmission began without clear-to-send");
    AST_DTR_ADDRESSED: assert property (@(posedge clk) disable iff (!rst_n)
        !dtr_local_n_q |-> $past(addr_s) && $past(cmd_q[serial_port_pkg::CMD_DTR]))
        else $error("Terminal-ready asserted by unaddressed unit");
    AST_RESET_PIN: assert property (@(posedge clk) disable iff (!rst_n)
        prst_s |=> expect_mode_q && !rx_ready && !tx_ready && serial_tx_line == 1'b0)
        else $error("Reset input did not restore initial state");
    AST_IDLE_LINE_INVERTED: assert property (@(posedge clk) disable iff (!rst_n)
        (tx_st_q == serial_port_pkg::S_STOP && !int_rst) |=> serial_tx_line == 1'b0)
        else $error("Stop bit not inverted on the bus");
endmodule

// ===== test/remote_controller.sv
`timescale 1ns/1ps
module remote_controller (
    // Bit clock
    input wire logic bclk,
    // Serial bus, inverted sense
    input wire logic serial_tx_line,
    output logic serial_rx_line,
    // Handshake
    output logic data_set_ready_n
);
    initial begin
        serial_rx_line = 1'b0;
        data_set_ready_n = 1'b1;
    end
    ////////////////////////////////////////////////////////////////
    // Bus level is the inverse of the port level, so idle mark reads 0 here
    task automatic send(input logic [7:0] b, input logic pe, input logic ev);
        logic [10:0] f;
        f = pe ? {1'b1, ev ? ^b : ~^b, b, 1'b0} : {2'b11, b, 1'b0};
        data_set_ready_n = 1'b0;
        for (int i = 0; i < 11; i++) begin
            @(negedge bclk);
            serial_rx_line = ~f[i];
            repeat (15) @(negedge bclk);
        end
        data_set_ready_n = 1'b1;
    endtask
    // Bounded wait for a start bit, then mid-bit sampling
    task automatic recv(input int lim, output logic seen, output logic [7:0] d,
                        output logic [1:0] tail);
        logic [9:0] r;
        seen = 1'b0;
        r = '0;
        for (int i = 0; i < lim && !seen; i++) begin
            @(posedge bclk);
            seen = serial_tx_line;
        end
        if (seen) begin
            repeat (8) @(posedge bclk);
            for (int i = 0; i < 10; i++) begin
                repeat (16) @(posedge bclk);
                r[i] = ~serial_tx_line;
            end
        end
        d = r[7:0];
        tail = r[9:8];
    endtask
endmodule

// ===== test/serial_port_device_tb_top.sv
`timescale 1ns/1ps
module serial_port_device_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic port_reset = 1'b0, ce_n = 1'b1, sel = 1'b0, rd_n = 1'b1, wr_n = 1'b1;
    logic cts_n = 1'b1, addr = 1'b1, chain_n = 1'b1, bclk = 1'b0, seen;
    logic [7:0] din = 8'h00, dout, got, exp;
    logic oe, rx_ready, tx_ready, dtr_n, rts_n, rxl, txl, dsr_n;
    logic [1:0] tail, div = 2'h0;
    int seed = 7866, miscompares = 0, comparisons = 0;
    logic [7:0] mode_tab [3] = '{8'h00, 8'h01, 8'h03};
    logic [7:0] tx_q [$];

    serial_port_device u_serial_port_device (
        .clk(clk), .rst_n(rst_n), .port_reset(port_reset), .chip_enable_n(ce_n),
        .ctrl_data_sel(sel), .read_n(rd_n), .write_n(wr_n), .data_in(din),
        .data_out(dout), .data_oe(oe), .rx_ready(rx_ready), .tx_ready(tx_ready),
        .receive_bit_clock_n(bclk), .transmit_bit_clock_n(bclk),
        .clear_to_send_n(cts_n), .data_set_ready_n(dsr_n), .unit_addressed(addr),
        .chain_terminal_ready_n(chain_n), .chain_request_to_send_n(1'b1),
        .terminal_ready_n(dtr_n), .request_to_send_n(rts_n),
        .serial_rx_line(rxl), .serial_tx_line(txl));
    remote_controller u_remote_controller (
        .bclk(bclk), .serial_tx_line(txl), .serial_rx_line(rxl), .data_set_ready_n(dsr_n));

    ////////////////////////////////////////////////////////////////
    initial forever #5 clk = ~clk;
    // Bit clock well below clk so the port's synchronisers see every edge
    always @(negedge clk) begin
        div <= div + 2'h1;
        if (div == 2'h3) bclk <= ~bclk;
    end

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Strobes held well past the port's input filter
    task automatic bus(input logic s, input logic w, input logic [7:0] d,
                       output logic [7:0] q);
        cyc(1);
        ce_n = 1'b0;
        sel = s;
        din = d;
        wr_n = ~w;
        rd_n = w;
        cyc(8);
        q = dout;
        chk("data_oe", {7'h0, ~w}, {7'h0, oe});
        wr_n = 1'b1;
        rd_n = 1'b1;
        ce_n = 1'b1;
        cyc(8);
    endtask
    task automatic test_done();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        cyc(60000);
        miscompares++;
        test_done();
    end

    initial begin
        cyc(10);
        rst_n = 1'b1;
        cyc(6);
        chk("tx_ready", 8'h00, {7'h0, tx_ready});
        chk("tx_line", 8'h00, {7'h0, txl});
        rd_n = 1'b0;
        wr_n = 1'b0;
        din = 8'h01;
        cyc(10);
        chk("data_oe", 8'h00, {7'h0, oe});
        rd_n = 1'b1;
        wr_n = 1'b1;
        cyc(6);
        foreach (mode_tab[m]) begin
            bus(1'b1, 1'b1, mode_tab[m], got);
            bus(1'b1, 1'b1, 8'h27, got);
            chk("dtr_n", 8'h00, {7'h0, dtr_n});
            chk("rts_n", 8'h00, {7'h0, rts_n});
            chk("tx_ready", 8'h01, {7'h0, tx_ready});
            tx_q.push_back(8'($random(seed)));
            bus(1'b0, 1'b1, tx_q[0], got);
            chk("tx_ready", 8'h00, {7'h0, tx_ready});
            u_remote_controller.recv(40, seen, got, tail);
            chk("early start", 8'h00, {7'h0, seen});
            cts_n = 1'b0;
            u_remote_controller.recv(40, seen, got, tail);
            exp = tx_q.pop_front();
            chk("tx start", 8'h01, {7'h0, seen});
            chk("tx data", exp, got);
            chk("tx tail", {6'h0, mode_tab[m][0] ? {1'b1, mode_tab[m][1] ? ^exp : ~^exp}
                : 2'b11}, {6'h0, tail});
            cts_n = 1'b1;
            exp = 8'($random(seed));
            fork
                u_remote_controller.send(exp, mode_tab[m][0], mode_tab[m][1]);
                begin
                    cyc(300);
                    bus(1'b1, 1'b0, 8'h00, got);
                    chk("status dsr", 8'h01, {7'h0, got[serial_port_pkg::STAT_DSR]});
                end
            join
            cyc(100);
            chk("rx_ready", 8'h01, {7'h0, rx_ready});
            bus(1'b1, 1'b0, 8'h00, got);
            chk("status rx", 8'h01, {7'h0, got[serial_port_pkg::STAT_RX_RDY]});
            chk("status err", 8'h00,
                {5'h0, got[serial_port_pkg::STAT_FRM_ERR:serial_port_pkg::STAT_PAR_ERR]});
            bus(1'b0, 1'b0, 8'h00, got);
            chk("rx data", exp, got);
            chk("rx_ready", 8'h00, {7'h0, rx_ready});
            addr = 1'b0;
            cyc(8);
            chk("dtr_n", 8'h01, {7'h0, dtr_n});
            chain_n = 1'b0;
            cyc(8);
            chk("dtr_n", 8'h00, {7'h0, dtr_n});
            chain_n = 1'b1;
            addr = 1'b1;
            bus(1'b1, 1'b1, 8'h40, got);
        end
        bus(1'b1, 1'b1, 8'h00, got);
        bus(1'b1, 1'b1, 8'h21, got);
        port_reset = 1'b1;
        cyc(8);
        port_reset = 1'b0;
        cyc(8);
        chk("tx_ready", 8'h00, {7'h0, tx_ready});
        chk("rts_n", 8'h01, {7'h0, rts_n});
        test_done();
    end
endmodule
